// ==== inc/crdec_pkg.sv ====
// Purpose: constants and types for the compact record decoder
// Assumes: byte-serial input, one byte per accepted cycle
// Notes: timestamps are seconds after the message reference instant
package crdec_pkg;
    localparam int BYTE_W = 8;
    localparam int GROUP_W = 7;
    localparam int MANT_W = 35;
    localparam int TS_W = 40;
    localparam int VAL_W = 48;
    localparam int PAR_W = 4;
    localparam int NPARAM = 16;
    localparam int MAX_NUM_BYTES = 5;
    localparam int CONT_BIT = 7;
    localparam int SIGN_BIT = 3;
    localparam int SINGLE_BIT = 2;
    localparam int TYPE_LSB = 4;
    localparam int UNIT_LSB = 0;
    localparam int EXP_LSB = 0;
    localparam logic [TS_W-1:0] TS_RESET = 40'h00_0000_0000;
    localparam logic [VAL_W-1:0] VAL_RESET = 48'h0000_0000_0000;
    localparam logic [TS_W-1:0] SEC_PER_DAY = 40'h00_0001_5180;
    localparam logic [TS_W-1:0] SEC_PER_HOUR = 40'h00_0000_0E10;
    localparam logic [TS_W-1:0] SEC_PER_MIN = 40'h00_0000_003C;
    localparam logic [TS_W-1:0] SEC_PER_SEC = 40'h00_0000_0001;
    localparam logic [1:0] UNIT_DAY = 2'h0;
    localparam logic [1:0] UNIT_HOUR = 2'h1;
    localparam logic [1:0] UNIT_MIN = 2'h2;
    localparam logic [1:0] UNIT_SEC = 2'h3;

    typedef enum logic [1:0] {
        CRD_IDLE = 2'b00,
        CRD_TIME = 2'b01,
        CRD_VALUE = 2'b10
    } crdec_state_type;
endpackage

// ==== inc/crdec_num_if.sv ====
// Purpose: carries number bytes to the mantissa assembler
// Assumes: one clock domain
// Notes: start clears, take adds one group
`timescale 1ns/1ns
interface crdec_num_if;
    import crdec_pkg::*;
    logic start;
    logic take;
    logic [BYTE_W-1:0] data;
    logic [MANT_W-1:0] mant;
    logic [2:0] count;

    modport host (output start, output take, output data,
        input mant, input count);
    modport asm (input start, input take, input data,
        output mant, output count);
endinterface

// ==== logic/crdec_mant.sv ====
// Purpose: assembles number-byte groups into one unsigned mantissa
// Assumes: start and take never in the same cycle
// Notes: mant is combinational, includes the byte taken this cycle
`timescale 1ns/1ns
module crdec_mant (
    input wire logic CLOCK_IN,       // system clock
    input wire logic SYS_RST_IN,     // async reset, active high
    crdec_num_if.asm num             // group feed
);
    import crdec_pkg::*;

    logic [MANT_W-1:0] mant_r;
    logic [MANT_W-1:0] mant_nxt;
    logic [2:0] count_r;
    logic [2:0] count_nxt;
    logic [MANT_W-1:0] grp;

    always_comb begin
        mant_nxt = mant_r;
        count_nxt = count_r;
        grp = {{(MANT_W-GROUP_W){1'b0}}, num.data[GROUP_W-1:0]};
        if (num.start) begin
            mant_nxt = '0;
            count_nxt = 3'h0;
        end else if (num.take && count_r < 3'(MAX_NUM_BYTES)) begin
            // low group first, weight 128 per step
            mant_nxt = mant_r | (grp << (GROUP_W * count_r));
            count_nxt = count_r + 3'h1;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            mant_r <= '0;
            count_r <= 3'h0;
        end else begin
            mant_r <= mant_nxt;
            count_r <= count_nxt;
        end
    end

    assign num.mant = mant_nxt;
    assign num.count = count_r;
endmodule

// ==== logic/crdec_top.sv ====
// Purpose: decodes compacted time/value records into timestamped values
// Assumes: MSG_START_IN pulses before the first byte of each message
// Notes: values are signed integers scaled by 10^exponent, exponent output
`timescale 1ns/1ns
module crdec_top (
    input wire logic CLOCK_IN, // system clock
    input wire logic SYS_RST_IN, // async reset, high
    input wire logic MSG_START_IN, // new message pulse
    input wire logic BYTE_VALID_IN, // byte strobe
    input wire logic [crdec_pkg::BYTE_W-1:0] BYTE_IN, // payload byte
    output logic OUT_VALID_OUT, // result strobe
    output logic [crdec_pkg::PAR_W-1:0] OUT_PARAM_OUT, // parameter number
    output logic [crdec_pkg::TS_W-1:0] OUT_TIME_OUT, // seconds since ref
    output logic [crdec_pkg::VAL_W-1:0] OUT_VALUE_OUT, // running value
    output logic [2:0] OUT_EXP_OUT, // decimal exponent
    output logic FORMAT_ERR_OUT // record too long pulse
);
    import crdec_pkg::*;

    crdec_num_if num ();

    crdec_mant u_mant (
        .CLOCK_IN(CLOCK_IN),
        .SYS_RST_IN(SYS_RST_IN),
        .num(num)
    );

    crdec_state_type state_r, state_nxt;
    logic [BYTE_W-1:0] hdr_r, hdr_nxt;
    logic [TS_W-1:0] ts_r, ts_nxt;
    logic [VAL_W-1:0] vals_r [NPARAM];
    logic [VAL_W-1:0] vals_nxt [NPARAM];
    logic ov_r, ov_nxt;
    logic [PAR_W-1:0] op_r, op_nxt;
    logic [TS_W-1:0] ot_r, ot_nxt;
    logic [VAL_W-1:0] ovl_r, ovl_nxt;
    logic [2:0] oe_r, oe_nxt;
    logic err_r, err_nxt;
    logic [PAR_W-1:0] par;
    logic [VAL_W-1:0] newval;
    logic [TS_W-1:0] dt;

    function automatic logic [TS_W-1:0] unit_secs(input logic [1:0] u);
        case (u)
            UNIT_DAY: unit_secs = SEC_PER_DAY;
            UNIT_HOUR: unit_secs = SEC_PER_HOUR;
            UNIT_MIN: unit_secs = SEC_PER_MIN;
            default: unit_secs = SEC_PER_SEC;
        endcase
    endfunction

    function automatic logic [TS_W-1:0] ts_step(input logic [TS_W-1:0] t,
        input logic [TS_W-1:0] d, input logic neg);
        ts_step = neg ? t - d : t + d;
    endfunction

    assign num.data = BYTE_IN;

    always_comb begin
        state_nxt = state_r;
        hdr_nxt = hdr_r;
        ts_nxt = ts_r;
        vals_nxt = vals_r;
        ov_nxt = 1'b0;
        op_nxt = op_r;
        ot_nxt = ot_r;
        ovl_nxt = ovl_r;
        oe_nxt = oe_r;
        err_nxt = 1'b0;
        num.start = 1'b0;
        num.take = 1'b0;
        par = hdr_r[TYPE_LSB +: PAR_W];
        newval = VAL_RESET;
        dt = TS_RESET;
        if (MSG_START_IN) begin
            state_nxt = CRD_IDLE;
            ts_nxt = TS_RESET;
            for (int i = 0; i < NPARAM; i++) begin
                vals_nxt[i] = VAL_RESET;
            end
            num.start = 1'b1;
        end else if (BYTE_VALID_IN) begin
            case (state_r)
                CRD_IDLE: begin
                    hdr_nxt = BYTE_IN;
                    num.start = 1'b1;
                    if (BYTE_IN[TYPE_LSB +: PAR_W] == '0) begin
                        if (BYTE_IN[SINGLE_BIT]) begin
                            ts_nxt = ts_step(ts_r,
                                unit_secs(BYTE_IN[UNIT_LSB +: 2]),
                                BYTE_IN[SIGN_BIT]);
                        end else begin
                            state_nxt = CRD_TIME;
                        end
                    end else begin
                        state_nxt = CRD_VALUE;
                    end
                end
                CRD_TIME, CRD_VALUE: begin
                    num.take = 1'b1;
                    if (num.count == 3'(MAX_NUM_BYTES-1)
                        && BYTE_IN[CONT_BIT]) begin
                        err_nxt = 1'b1;
                    end
                    if (!BYTE_IN[CONT_BIT] || err_nxt) begin
                        state_nxt = CRD_IDLE;
                        if (state_r == CRD_TIME) begin
                            dt = TS_W'(num.mant
                                * unit_secs(hdr_r[UNIT_LSB +: 2]));
                            ts_nxt = ts_step(ts_r, dt, hdr_r[SIGN_BIT]);
                        end else begin
                            newval = hdr_r[SIGN_BIT]
                                ? vals_r[par] - VAL_W'(num.mant)
                                : vals_r[par] + VAL_W'(num.mant);
                            vals_nxt[par] = newval;
                            ov_nxt = 1'b1;
                            op_nxt = par;
                            ot_nxt = ts_r;
                            ovl_nxt = newval;
                            oe_nxt = hdr_r[EXP_LSB +: 3];
                        end
                    end
                end
                default: state_nxt = CRD_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_r <= CRD_IDLE;
            hdr_r <= 8'h00;
            ts_r <= TS_RESET;
            for (int i = 0; i < NPARAM; i++) begin
                vals_r[i] <= VAL_RESET;
            end
            ov_r <= 1'b0;
            op_r <= 4'h0;
            ot_r <= TS_RESET;
            ovl_r <= VAL_RESET;
            oe_r <= 3'h0;
            err_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            hdr_r <= hdr_nxt;
            ts_r <= ts_nxt;
            vals_r <= vals_nxt;
            ov_r <= ov_nxt;
            op_r <= op_nxt;
            ot_r <= ot_nxt;
            ovl_r <= ovl_nxt;
            oe_r <= oe_nxt;
            err_r <= err_nxt;
        end
    end

    assign OUT_VALID_OUT = ov_r;
    assign OUT_PARAM_OUT = op_r;
    assign OUT_TIME_OUT = ot_r;
    assign OUT_VALUE_OUT = ovl_r;
    assign OUT_EXP_OUT = oe_r;
    assign FORMAT_ERR_OUT = err_r;
endmodule

// ==== verif/crdec_monitor.sv ====
// Purpose: port checker for the record decoder
// Assumes: one clock, async high reset
// Notes: bound from the bench top
`timescale 1ns/1ns
module crdec_monitor (
    input wire logic CLOCK_IN, // clock
    input wire logic SYS_RST_IN, // reset
    input wire logic MSG_START_IN, // message start
    input wire logic BYTE_VALID_IN, // byte strobe
    input wire logic [7:0] BYTE_IN, // byte
    input wire logic OUT_VALID_OUT, // result strobe
    input wire logic [3:0] OUT_PARAM_OUT, // parameter
    input wire logic [39:0] OUT_TIME_OUT, // time
    input wire logic [47:0] OUT_VALUE_OUT, // value
    input wire logic [2:0] OUT_EXP_OUT, // exponent
    input wire logic FORMAT_ERR_OUT // error strobe
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    chk_valid_pulse: assert property (OUT_VALID_OUT |=> !OUT_VALID_OUT)
        else $error("result strobe too long");
    chk_err_pulse: assert property (FORMAT_ERR_OUT |=> !FORMAT_ERR_OUT)
        else $error("error strobe too long");
    chk_valid_cause: assert property (OUT_VALID_OUT |->
        FORMAT_ERR_OUT ||
        $past(BYTE_VALID_IN && !MSG_START_IN && !BYTE_IN[7]))
        else $error("strobe without closing byte");
    chk_param_nonzero: assert property (
        OUT_VALID_OUT |-> OUT_PARAM_OUT != 0)
        else $error("parameter zero reported");
    chk_data_hold: assert property (
        !OUT_VALID_OUT |-> $stable(OUT_PARAM_OUT)
        && $stable(OUT_VALUE_OUT) && $stable(OUT_EXP_OUT))
        else $error("result data moved without strobe");
    chk_time_hold: assert property (
        !OUT_VALID_OUT |-> $stable(OUT_TIME_OUT))
        else $error("time moved without strobe");
    chk_err_cause: assert property (FORMAT_ERR_OUT |->
        $past(BYTE_VALID_IN && BYTE_IN[7]))
        else $error("error without continued byte");
    chk_start_abort: assert property (MSG_START_IN |=> !OUT_VALID_OUT)
        else $error("strobe right after message start");
    cov_value: cover property (OUT_VALID_OUT);
    cov_err: cover property (FORMAT_ERR_OUT);
    cov_err_value: cover property (OUT_VALID_OUT && FORMAT_ERR_OUT);
    cov_start: cover property (MSG_START_IN ##1 BYTE_VALID_IN);
endmodule

// ==== verif/crdec_producer.sv ====
// Purpose: message producer feeding compacted bytes
// Assumes: caller chains tasks with no gap
// Notes: released data lines toggle each idle cycle
`timescale 1ns/1ns
module crdec_producer (
    input wire logic clk_in, // clock
    output logic start_out, // message start
    output logic vld_out, // byte strobe
    output logic [7:0] data_out // byte
);
    initial begin
        start_out = 1'b0;
        vld_out = 1'b0;
        data_out = 8'h00;
    end
    task automatic put(input logic [7:0] b);
        @(posedge clk_in);
        start_out <= 1'b0;
        vld_out <= 1'b1;
        data_out <= b;
    endtask
    task automatic rec(input logic [7:0] h, input longint m, input int n,
        input bit lc);
        put(h);
        for (int k = 0; k < n; k++)
            put({1'(k < n - 1 || lc), 7'(m >> (7 * k))});
    endtask
    task automatic begin_msg();
        @(posedge clk_in);
        start_out <= 1'b1;
        vld_out <= 1'b0;
        data_out <= ~data_out;
    endtask
    task automatic idle();
        @(posedge clk_in);
        start_out <= 1'b0;
        vld_out <= 1'b0;
        data_out <= ~data_out;
    endtask
endmodule

// ==== verif/crdec_top_tb.sv ====
// Purpose: self-checking bench for the record decoder
// Assumes: producer drives bytes at rising edges
// Notes: integer model predicts every result strobe
`timescale 1ns/1ns
module crdec_top_tb;
    typedef struct {longint p; longint t; longint v; longint e;}
        crdec_exp_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic st, vld, ovld, ferr;
    logic [7:0] byt;
    logic [3:0] opar;
    logic [39:0] otime;
    logic [47:0] oval;
    logic [2:0] oexp;
    int err_total = 0;
    int n_tests = 0;
    int n_ferr = 0;
    logic [31:0] seed = 32'h2E9A8ACB;
    longint ts = 0;
    longint vals [16];
    longint secs [4] = '{86400, 3600, 60, 1};
    crdec_exp_type eq [$];
    crdec_exp_type x;
    initial forever #50 clk = ~clk;
    crdec_producer prod (.clk_in(clk), .start_out(st), .vld_out(vld),
        .data_out(byt));
    crdec_top dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .MSG_START_IN(st),
        .BYTE_VALID_IN(vld), .BYTE_IN(byt), .OUT_VALID_OUT(ovld),
        .OUT_PARAM_OUT(opar), .OUT_TIME_OUT(otime), .OUT_VALUE_OUT(oval),
        .OUT_EXP_OUT(oexp), .FORMAT_ERR_OUT(ferr));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int ng(longint m);
        int n = 1;
        while ((m >> (7 * n)) != 0)
            n++;
        return n;
    endfunction
    task automatic check(string nm, logic [47:0] got, logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic tval(int p, int s, int e, longint m);
        prod.rec({4'(p), 1'(s), 3'(e)}, m, ng(m), 1'b0);
        vals[p] = s ? vals[p] - m : vals[p] + m;
        eq.push_back('{p, ts, vals[p], e});
    endtask
    task automatic ttime(int u, int s, int one, longint m, int n, bit lc);
        if (one)
            prod.put({4'h0, 1'(s), 1'b1, 2'(u)});
        else
            prod.rec({4'h0, 1'(s), 1'b0, 2'(u)}, m, n, lc);
        ts = ts + (s ? -1 : 1) * (one ? 1 : m) * secs[u];
    endtask
    task automatic wrap_up();
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        if (ferr === 1'b1)
            n_ferr++;
        if (ovld === 1'b1 && eq.size() != 0) begin
            x = eq.pop_front();
            check("param", 48'(opar), 48'(x.p));
            check("time", 48'(otime), 48'(x.t[39:0]));
            check("value", oval, 48'(x.v));
            check("exp", 48'(oexp), 48'(x.e));
        end else if (ovld === 1'b1)
            check("strobe", 48'h1, 48'h0);
    end
    initial begin
        longint m;
        vals = '{default: 0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        prod.begin_msg();
        ttime(0, 0, 0, 1234, ng(1234), 1'b0);
        tval(1, 0, 5, 257);
        tval(1, 1, 0, 8438017);
        for (int k = 0; k < 8; k++) begin
            m = rnd() >> (rnd() % 32);
            ttime(k / 2, k % 2, 1, 0, 0, 1'b0);
            ttime(k / 2, k % 2, 0, m, ng(m), 1'b0);
            tval(1 + rnd() % 15, rnd() % 2, k, rnd() >> (rnd() % 32));
        end
        m = rnd();
        ttime(3, 0, 0, m, 5, 1'b1);
        m = rnd();
        prod.rec(8'h30, m, 5, 1'b1);
        vals[3] = vals[3] + m;
        eq.push_back('{3, ts, vals[3], 0});
        tval(3, 0, 2, 100);
        prod.put(8'h21);
        prod.put(8'h85);
        prod.begin_msg();
        ts = 0;
        vals = '{default: 0};
        tval(2, 0, 0, 5);
        ttime(3, 1, 1, 0, 0, 1'b0);
        tval(2, 1, 1, 9);
        repeat (4) prod.idle();
        check("format errors", 48'(n_ferr), 48'h2);
        check("pending", 48'(eq.size()), 48'h0);
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule
bind crdec_top crdec_monitor mon (.CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN), .MSG_START_IN(MSG_START_IN),
    .BYTE_VALID_IN(BYTE_VALID_IN), .BYTE_IN(BYTE_IN),
    .OUT_VALID_OUT(OUT_VALID_OUT), .OUT_PARAM_OUT(OUT_PARAM_OUT),
    .OUT_TIME_OUT(OUT_TIME_OUT), .OUT_VALUE_OUT(OUT_VALUE_OUT),
    .OUT_EXP_OUT(OUT_EXP_OUT), .FORMAT_ERR_OUT(FORMAT_ERR_OUT));
